/* core/fos_pkg.sv */
// Constants and types for the flash option and security block
package fos_pkg;
   // Register byte offsets on the bus
   localparam logic [7:0]  OFS_OPTIONS    = 8'h00;
   localparam logic [7:0]  OFS_CONFIG     = 8'h04;
   localparam logic [7:0]  OFS_STATUS     = 8'h08;
   // Options register fields
   localparam int          OPT_KEY_EN_BIT = 7;
   localparam int          OPT_NORED_BIT  = 6;
   localparam logic [7:0]  OPT_READ_MASK  = 8'hc3;
   localparam logic [7:0]  OPT_RESET      = 8'h00;
   // Configuration register fields
   localparam int          CFG_KEY_ACC_BIT = 5;
   localparam logic [7:0]  CFG_RW_MASK    = 8'he0;
   localparam logic [7:0]  CFG_RESET      = 8'h00;
   // Status register fields
   localparam int          STS_SECURE_BIT = 0;
   localparam int          STS_FAIL_BIT   = 1;
   localparam int          STS_UNLOCK_BIT = 2;
   localparam int          STS_CNT_LSB    = 4;
   // Security code patterns
   localparam logic [1:0]  SEC_UNSECURED  = 2'h2;
   localparam logic [1:0]  SEC_RESET      = 2'h0;
   // Backdoor key window in the flash address space
   localparam logic [15:0] KEY_BASE       = 16'hffb0;
   localparam int          KEY_BYTES      = 8;
   localparam int          KEY_IDX_W      = 3;
   localparam int          KEY_CNT_W      = 4;
   localparam logic [3:0]  KEY_CNT_FULL   = 4'h8;
   localparam logic [3:0]  KEY_CNT_ZERO   = 4'h0;
   // Bus answer states
   typedef enum logic [0:0] {
      BUS_WAIT   = 1'b0,
      BUS_ANSWER = 1'b1
   } fos_bus_t;
endpackage : fos_pkg

/* core/fos_flash_option_security.sv */
// Flash options, configuration and backdoor security logic with APB
`timescale 1ns/100ps
`default_nettype none

// Operation
// RULE_01 - Each reset reloads the options register from the option byte.
// RULE_02 - Options bits five to two always read as zero.
// RULE_03 - The options register reads any time and ignores all writes.
// RULE_04 - A clear backdoor key enable bit prevents any key unlock.
// RULE_05 - Only core firmware key writes count, debug writes do not.
// RULE_06 - Eight matching key bytes in ascending order unlock until reset.
// RULE_07 - Vector redirection is disabled when options bit six is one.
// RULE_08 - Only security code 10 means unsecured, all others mean secure.
// RULE_09 - While secure, memory requests from unsecured sources are denied.
// RULE_10 - A key match or a full blank check sets the security code to 10.
// RULE_11 - Configuration bits seven to five read and write at any time.
// RULE_12 - Configuration bits four to zero read zero and ignore writes.
// RULE_13 - With key access clear, key window writes start a flash command.
// RULE_14 - With key access set, key window writes are captured as key bytes.
// RULE_15 - With key access set, flash reads are flagged invalid.
// RULE_16 - Clearing key access compares the key and unlocks on a match.
// RULE_17 - Fewer than eight captured bytes make the comparison fail.
module fos_flash_option_security #(
   parameter int KEY_N = fos_pkg::KEY_BYTES
) (
   input  wire logic        CLOCK,
   input  wire logic        RESET_N,
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [7:0]  PADDR,
   input  wire logic [31:0] PWDATA,
   output var  logic [31:0] PRDATA,
   output var  logic        PREADY,
   output var  logic        PSLVERR,
   input  wire logic [7:0]  NONVOLATILE_OPTION_BYTE,
   input  wire logic [63:0] STORED_BACKDOOR_KEY,
   input  wire logic        ARRAY_WR_VALID,
   input  wire logic [15:0] ARRAY_WR_ADDR,
   input  wire logic [7:0]  ARRAY_WR_DATA,
   input  wire logic        ARRAY_WR_FROM_DEBUG,
   input  wire logic        BLANK_CHECK_PASS,
   input  wire logic        MEM_REQ_VALID,
   input  wire logic        MEM_REQ_UNSECURED_SRC,
   output var  logic        MEM_REQ_DENY,
   output var  logic        CMD_START,
   output var  logic [15:0] CMD_START_ADDR,
   output var  logic [7:0]  CMD_START_DATA,
   output var  logic        SECURE,
   output var  logic        VECTOR_REDIRECT_EN,
   output var  logic        FLASH_READ_INVALID,
   output var  logic        OPTIONS_LOADED
);

   // True when an address falls inside the backdoor key window
   function automatic logic in_key_window(input logic [15:0] a);
      in_key_window = (a[15:fos_pkg::KEY_IDX_W] ==
                       fos_pkg::KEY_BASE[15:fos_pkg::KEY_IDX_W]);
   endfunction : in_key_window

   // True for a mapped register offset
   function automatic logic is_mapped(input logic [7:0] a);
      is_mapped = (a == fos_pkg::OFS_OPTIONS) ||
                  (a == fos_pkg::OFS_CONFIG)  ||
                  (a == fos_pkg::OFS_STATUS);
   endfunction : is_mapped

   // Bus state
   fos_pkg::fos_bus_t  bus_r,     bus_nxt;
   logic [31:0]        prdata_r,  prdata_nxt;
   logic               pslverr_r, pslverr_nxt;
   // Options and security state
   logic               loaded_r,  loaded_nxt;
   logic [7:0]         opt_r,     opt_nxt;
   logic [1:0]         sec_r,     sec_nxt;
   // Configuration register
   logic [7:0]         cfg_r,     cfg_nxt;
   // Key capture state
   logic [7:0]         key_buf_r [KEY_N];
   logic [7:0]         key_buf_nxt [KEY_N];
   logic [fos_pkg::KEY_CNT_W-1:0] key_cnt_r, key_cnt_nxt;
   logic               order_ok_r, order_ok_nxt;
   logic               fail_r,    fail_nxt;
   logic               unlock_r,  unlock_nxt;
   // Registered side outputs
   logic               cmd_r,     cmd_nxt;
   logic [15:0]        cmd_addr_r, cmd_addr_nxt;
   logic [7:0]         cmd_data_r, cmd_data_nxt;
   logic               deny_r,    deny_nxt;
   logic               secure_r,  secure_nxt;
   logic               redir_r,   redir_nxt;
   logic               rdinv_r,   rdinv_nxt;

   // Shared decode terms
   logic               bus_done;
   logic               cfg_wr;
   logic               key_acc;
   logic               key_acc_clear;
   logic               key_wr;
   logic               key_match;
   logic [7:0]         rd_byte;
   logic [7:0]         sts_byte;

   // Access completes on the edge where PREADY is seen high
   always_comb begin
      bus_done = PSEL && PENABLE && (bus_r == fos_pkg::BUS_ANSWER);
      cfg_wr   = bus_done && PWRITE && (PADDR == fos_pkg::OFS_CONFIG);
      key_acc  = cfg_r[fos_pkg::CFG_KEY_ACC_BIT];
      key_acc_clear = cfg_wr && key_acc &&
                      !PWDATA[fos_pkg::CFG_KEY_ACC_BIT];        // RULE_16
      key_wr   = ARRAY_WR_VALID && in_key_window(ARRAY_WR_ADDR);
   end

   // Comparison of the captured key against the stored key
   always_comb begin
      key_match = opt_r[fos_pkg::OPT_KEY_EN_BIT] &&           // RULE_04
                  (key_cnt_r == fos_pkg::KEY_CNT_FULL) &&      // RULE_17
                  order_ok_r;                                  // RULE_06
      for (int i = 0; i < KEY_N; i++) begin
         if (key_buf_r[i] != STORED_BACKDOOR_KEY[8*i +: 8]) begin
            key_match = 1'b0;                                  // RULE_06
         end
      end
   end

   // Status byte: secure, last compare failed, unlocked by key, count
   always_comb begin
      sts_byte = 8'h00;
      sts_byte[fos_pkg::STS_SECURE_BIT] = secure_r;
      sts_byte[fos_pkg::STS_FAIL_BIT]   = fail_r;
      sts_byte[fos_pkg::STS_UNLOCK_BIT] = unlock_r;
      sts_byte[fos_pkg::STS_CNT_LSB +: fos_pkg::KEY_CNT_W] = key_cnt_r;
   end

   // Read data multiplexer
   always_comb begin
      case (PADDR)
         fos_pkg::OFS_OPTIONS: begin
            rd_byte = {opt_r[7:2], sec_r} & fos_pkg::OPT_READ_MASK; // RULE_02
         end
         fos_pkg::OFS_CONFIG: begin
            rd_byte = cfg_r & fos_pkg::CFG_RW_MASK;            // RULE_12
         end
         fos_pkg::OFS_STATUS: begin
            rd_byte = sts_byte;
         end
         default: begin
            rd_byte = 8'h00;
         end
      endcase
   end

   // APB slave: one wait cycle, then answer
   always_comb begin
      bus_nxt     = bus_r;
      prdata_nxt  = prdata_r;
      pslverr_nxt = pslverr_r;
      case (bus_r)
         fos_pkg::BUS_WAIT: begin
            if (PSEL && PENABLE) begin
               bus_nxt     = fos_pkg::BUS_ANSWER;
               prdata_nxt  = PWRITE ? 32'h0000_0000 : {24'h00_0000, rd_byte};
               pslverr_nxt = !is_mapped(PADDR);
            end
         end
         fos_pkg::BUS_ANSWER: begin
            bus_nxt     = fos_pkg::BUS_WAIT;
            prdata_nxt  = 32'h0000_0000;
            pslverr_nxt = 1'b0;
         end
         default: begin
            bus_nxt     = fos_pkg::BUS_WAIT;
            prdata_nxt  = 32'h0000_0000;
            pslverr_nxt = 1'b0;
         end
      endcase
   end

   always_ff @(posedge CLOCK or negedge RESET_N) begin
      if (!RESET_N) begin
         bus_r     <= fos_pkg::BUS_WAIT;
         prdata_r  <= 32'h0000_0000;
         pslverr_r <= 1'b0;
      end else begin
         bus_r     <= bus_nxt;
         prdata_r  <= prdata_nxt;
         pslverr_r <= pslverr_nxt;
      end
   end

   // Options load after reset release and security code updates
   always_comb begin
      loaded_nxt = 1'b1;
      opt_nxt    = opt_r;                                      // RULE_03
      sec_nxt    = sec_r;
      if (!loaded_r) begin
         opt_nxt = NONVOLATILE_OPTION_BYTE & fos_pkg::OPT_READ_MASK; // RULE_01
         sec_nxt = NONVOLATILE_OPTION_BYTE[1:0];               // RULE_01
      end else if ((key_acc_clear && key_match) || BLANK_CHECK_PASS) begin
         sec_nxt = fos_pkg::SEC_UNSECURED;                     // RULE_10
      end
   end

   always_ff @(posedge CLOCK or negedge RESET_N) begin
      if (!RESET_N) begin
         loaded_r <= 1'b0;
         opt_r    <= fos_pkg::OPT_RESET;
         sec_r    <= fos_pkg::SEC_RESET;
      end else begin
         loaded_r <= loaded_nxt;
         opt_r    <= opt_nxt;
         sec_r    <= sec_nxt;
      end
   end

   // Configuration register, upper three bits writable
   always_comb begin
      cfg_nxt = cfg_r;
      if (cfg_wr) begin
         cfg_nxt = PWDATA[7:0] & fos_pkg::CFG_RW_MASK;         // RULE_11
      end
   end

   always_ff @(posedge CLOCK or negedge RESET_N) begin
      if (!RESET_N) begin
         cfg_r <= fos_pkg::CFG_RESET;
      end else begin
         cfg_r <= cfg_nxt;
      end
   end

   // Key byte capture and comparison bookkeeping
   always_comb begin
      key_buf_nxt  = key_buf_r;
      key_cnt_nxt  = key_cnt_r;
      order_ok_nxt = order_ok_r;
      fail_nxt     = fail_r;
      unlock_nxt   = unlock_r;
      if (key_acc_clear) begin
         // Comparison ends the entry; partial bytes are dropped
         fail_nxt     = !key_match;                            // RULE_17
         unlock_nxt   = unlock_r || key_match;
         key_cnt_nxt  = fos_pkg::KEY_CNT_ZERO;
         order_ok_nxt = 1'b1;
         for (int i = 0; i < KEY_N; i++) begin
            key_buf_nxt[i] = 8'h00;
         end
      end else if (key_acc && key_wr && !ARRAY_WR_FROM_DEBUG) begin // RULE_05
         if (key_cnt_r < fos_pkg::KEY_CNT_FULL) begin
            key_buf_nxt[key_cnt_r[fos_pkg::KEY_IDX_W-1:0]] =
               ARRAY_WR_DATA;                                  // RULE_14
            key_cnt_nxt = key_cnt_r + 4'h1;
            if (ARRAY_WR_ADDR[fos_pkg::KEY_IDX_W-1:0] !=
                key_cnt_r[fos_pkg::KEY_IDX_W-1:0]) begin
               order_ok_nxt = 1'b0;                            // RULE_06
            end
         end else begin
            order_ok_nxt = 1'b0;                               // RULE_06
         end
      end
   end

   always_ff @(posedge CLOCK or negedge RESET_N) begin
      if (!RESET_N) begin
         for (int i = 0; i < KEY_N; i++) begin
            key_buf_r[i] <= 8'h00;
         end
         key_cnt_r  <= fos_pkg::KEY_CNT_ZERO;
         order_ok_r <= 1'b1;
         fail_r     <= 1'b0;
         unlock_r   <= 1'b0;
      end else begin
         key_buf_r  <= key_buf_nxt;
         key_cnt_r  <= key_cnt_nxt;
         order_ok_r <= order_ok_nxt;
         fail_r     <= fail_nxt;
         unlock_r   <= unlock_nxt;
      end
   end

   // Command start, access deny and level outputs
   always_comb begin
      cmd_nxt      = key_wr && !key_acc;                       // RULE_13
      cmd_addr_nxt = cmd_nxt ? ARRAY_WR_ADDR : 16'h0000;
      cmd_data_nxt = cmd_nxt ? ARRAY_WR_DATA : 8'h00;
      secure_nxt   = (sec_nxt != fos_pkg::SEC_UNSECURED);      // RULE_08
      deny_nxt     = MEM_REQ_VALID && MEM_REQ_UNSECURED_SRC &&
                     secure_r;                                 // RULE_09
      redir_nxt    = loaded_nxt &&
                     !opt_nxt[fos_pkg::OPT_NORED_BIT];         // RULE_07
      rdinv_nxt    = cfg_nxt[fos_pkg::CFG_KEY_ACC_BIT];        // RULE_15
   end

   always_ff @(posedge CLOCK or negedge RESET_N) begin
      if (!RESET_N) begin
         cmd_r      <= 1'b0;
         cmd_addr_r <= 16'h0000;
         cmd_data_r <= 8'h00;
         secure_r   <= 1'b1;
         deny_r     <= 1'b0;
         redir_r    <= 1'b0;
         rdinv_r    <= 1'b0;
      end else begin
         cmd_r      <= cmd_nxt;
         cmd_addr_r <= cmd_addr_nxt;
         cmd_data_r <= cmd_data_nxt;
         secure_r   <= secure_nxt;
         deny_r     <= deny_nxt;
         redir_r    <= redir_nxt;
         rdinv_r    <= rdinv_nxt;
      end
   end

   // Port drive from flip-flops
   assign PRDATA             = prdata_r;
   assign PREADY             = bus_r;
   assign PSLVERR            = pslverr_r;
   assign CMD_START          = cmd_r;
   assign CMD_START_ADDR     = cmd_addr_r;
   assign CMD_START_DATA     = cmd_data_r;
   assign SECURE             = secure_r;
   assign MEM_REQ_DENY       = deny_r;
   assign VECTOR_REDIRECT_EN = redir_r;
   assign FLASH_READ_INVALID = rdinv_r;
   assign OPTIONS_LOADED     = loaded_r;

endmodule : fos_flash_option_security
`default_nettype wire

/* tb/fos_props.sv */
// Checker for the flash option and security block
`timescale 1ns/100ps
`default_nettype none
module fos_props (
   input wire logic        CLOCK,
   input wire logic        RESET_N,
   input wire logic        PSEL,
   input wire logic        PENABLE,
   input wire logic        PWRITE,
   input wire logic [7:0]  PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic [31:0] PRDATA,
   input wire logic        PREADY,
   input wire logic        ARRAY_WR_VALID,
   input wire logic [15:0] ARRAY_WR_ADDR,
   input wire logic        BLANK_CHECK_PASS,
   input wire logic        MEM_REQ_VALID,
   input wire logic        MEM_REQ_UNSECURED_SRC,
   input wire logic        MEM_REQ_DENY,
   input wire logic        CMD_START,
   input wire logic [15:0] CMD_START_ADDR,
   input wire logic        SECURE,
   input wire logic        VECTOR_REDIRECT_EN,
   input wire logic        FLASH_READ_INVALID,
   input wire logic        OPTIONS_LOADED
);
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (!RESET_N);
   // Bus steps
   sequence s_setup;
      PSEL && !PENABLE;
   endsequence
   sequence s_ans;
      !PREADY ##1 PREADY;
   endsequence
   sequence s_rd(logic [7:0] a);
      PREADY && !PWRITE && PADDR == a;
   endsequence
   AST_ONE_WAIT: assert property (s_setup |=> s_ans)
      else $error("answer not after one wait state");
   AST_PREADY_PULSE: assert property (PREADY |=> !PREADY)
      else $error("ready held too long");
   AST_OPT_ZERO: assert property (s_rd(fos_pkg::OFS_OPTIONS) |->
      (PRDATA & ~32'h000000c3) == 32'h0) else $error("options spare bits set");
   AST_CFG_ZERO: assert property (s_rd(fos_pkg::OFS_CONFIG) |->
      (PRDATA & ~32'h000000e0) == 32'h0) else $error("config low bits set");
   AST_CMD: assert property (ARRAY_WR_VALID &&
      ARRAY_WR_ADDR[15:3] == fos_pkg::KEY_BASE[15:3] |=>
      CMD_START == !$past(FLASH_READ_INVALID) &&
      (!CMD_START || CMD_START_ADDR == $past(ARRAY_WR_ADDR)))
      else $error("key window write handled wrongly");
   AST_KEY_ACCESS_ENABLE: assert property (PREADY && PWRITE &&
      PADDR == fos_pkg::OFS_CONFIG |=> FLASH_READ_INVALID == $past(PWDATA[5]))
      else $error("read invalid flag does not follow key access");
   AST_DENY: assert property (MEM_REQ_DENY ==
      $past(MEM_REQ_VALID && MEM_REQ_UNSECURED_SRC && SECURE))
      else $error("memory deny wrong");
   AST_UNLOCK_HOLD: assert property (!SECURE |=> !SECURE)
      else $error("security returned before reset");
   AST_BLANK: assert property (BLANK_CHECK_PASS &&
      OPTIONS_LOADED |-> ##[1:2] !SECURE) else $error("blank check no unlock");
   AST_REDIR: assert property (OPTIONS_LOADED &&
      $past(OPTIONS_LOADED) |-> $stable(VECTOR_REDIRECT_EN))
      else $error("redirect enable changed");
endmodule : fos_props
bind fos_flash_option_security fos_props props_u (.*);
`default_nettype wire

/* tb/fos_core_model.sv */
// Core and debug write source for the backdoor key window
`timescale 1ns/100ps
`default_nettype none
module fos_core_model (
   input  wire logic        clk,
   input  wire logic        go,
   input  wire logic        dbg,
   input  wire logic [3:0]  n,
   input  wire logic [63:0] key,
   output var  logic        vld = 1'b0,
   output var  logic [15:0] addr = 16'h0,
   output var  logic [7:0]  data = 8'h0,
   output var  logic        frm = 1'b0,
   output var  logic        busy = 1'b0
);
   // One burst of key bytes per go pulse
   always @(posedge clk) begin
      if (go) begin
         busy <= 1'b1;
         for (int i = 0; i < int'(n); i++) begin
            vld  <= 1'b1;
            addr <= fos_pkg::KEY_BASE + 16'(i);
            data <= key[8*i +: 8];
            frm  <= dbg;
            @(posedge clk);
         end
         // Released lines show the inverse
         vld  <= 1'b0;
         addr <= ~addr;
         data <= ~data;
         busy <= 1'b0;
      end
   end
endmodule : fos_core_model
`default_nettype wire

/* tb/tb_top.sv */
// Self-checking bench for the flash option and security block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   logic        CLOCK = 0, RESET_N = 0, PSEL = 0, PENABLE = 0, PWRITE = 0;
   logic        PREADY, PSLVERR, BLANK_CHECK_PASS = 0, MEM_REQ_VALID = 0;
   logic        MEM_REQ_UNSECURED_SRC = 0, MEM_REQ_DENY, CMD_START, SECURE;
   logic        ARRAY_WR_VALID, ARRAY_WR_FROM_DEBUG, VECTOR_REDIRECT_EN;
   logic        FLASH_READ_INVALID, OPTIONS_LOADED, go = 0, dbg = 0, mbusy;
   logic [7:0]  PADDR = 0, NONVOLATILE_OPTION_BYTE = 0, ARRAY_WR_DATA, nvb;
   logic [7:0]  CMD_START_DATA, m_q[$];
   logic [15:0] ARRAY_WR_ADDR, CMD_START_ADDR;
   logic [31:0] PWDATA = 0, PRDATA, rdat, d;
   logic [63:0] STORED_BACKDOOR_KEY = 0, kk = 0, cdat = 0;
   logic [3:0]  kn = 0;
   logic        rerr, ok;
   int          err_total = 0, num_checks = 0, cyc = 0, cmds = 0;
   int          seed = 61418, m_cfg = 0, m_code = 0;
   always #25 CLOCK = ~CLOCK;
   // Cycle ceiling and command pulse count
   always @(posedge CLOCK) begin
      cyc++;
      if (CMD_START === 1'b1) begin
         cmds++;
         cdat = {CMD_START_DATA, cdat[63:8]};
      end
      if (cyc == 20000) begin
         err_total++;
         test_done;
      end
   end
   fos_flash_option_security dut_u (
      .CLOCK(CLOCK), .RESET_N(RESET_N), .PSEL(PSEL), .PENABLE(PENABLE),
      .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
      .PREADY(PREADY), .PSLVERR(PSLVERR),
      .NONVOLATILE_OPTION_BYTE(NONVOLATILE_OPTION_BYTE),
      .STORED_BACKDOOR_KEY(STORED_BACKDOOR_KEY),
      .ARRAY_WR_VALID(ARRAY_WR_VALID), .ARRAY_WR_ADDR(ARRAY_WR_ADDR),
      .ARRAY_WR_DATA(ARRAY_WR_DATA),
      .ARRAY_WR_FROM_DEBUG(ARRAY_WR_FROM_DEBUG),
      .BLANK_CHECK_PASS(BLANK_CHECK_PASS), .MEM_REQ_VALID(MEM_REQ_VALID),
      .MEM_REQ_UNSECURED_SRC(MEM_REQ_UNSECURED_SRC),
      .MEM_REQ_DENY(MEM_REQ_DENY), .CMD_START(CMD_START),
      .CMD_START_ADDR(CMD_START_ADDR), .CMD_START_DATA(CMD_START_DATA),
      .SECURE(SECURE), .VECTOR_REDIRECT_EN(VECTOR_REDIRECT_EN),
      .FLASH_READ_INVALID(FLASH_READ_INVALID),
      .OPTIONS_LOADED(OPTIONS_LOADED));
   fos_core_model core_u (.clk(CLOCK), .go(go), .dbg(dbg), .n(kn), .key(kk),
      .vld(ARRAY_WR_VALID), .addr(ARRAY_WR_ADDR), .data(ARRAY_WR_DATA),
      .frm(ARRAY_WR_FROM_DEBUG), .busy(mbusy));
   task automatic test_done;
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : test_done
   task automatic chk_bit(input logic g, input logic e);
      num_checks++;
      if (g !== e) begin
         err_total++;
         $display("CHECK FAILED at %0t: flag %b not %b", $time, g, e);
      end
   endtask : chk_bit
   // One APB transfer, held until ready
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] wd);
      PSEL <= 1;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= wd;
      @(posedge CLOCK);
      PENABLE <= 1;
      do @(posedge CLOCK); while (PREADY !== 1'b1 && cyc < 20000);
      rdat = PRDATA;
      rerr = PSLVERR;
      PSEL <= 0;
      PENABLE <= 0;
      @(posedge CLOCK);
   endtask : apb
   task automatic chk_rd(input logic [7:0] a, input int e, input logic ee);
      apb(0, a, 32'h0);
      num_checks++;
      if (rdat !== 32'(e) || rerr !== ee) begin
         err_total++;
         $display("CHECK FAILED at %0t: read %h got %h", $time, a, rdat);
      end
   endtask : chk_rd
   task automatic rst(input logic [7:0] b);
      RESET_N <= 0;
      NONVOLATILE_OPTION_BYTE <= b;
      nvb = b;
      m_code = b[1:0];
      m_cfg = 0;
      repeat (4) @(posedge CLOCK);
      RESET_N <= 1;
      repeat (3) @(posedge CLOCK);
   endtask : rst
   // Key burst; the model keeps captured bytes
   task automatic send(input logic d_, input logic [3:0] n_,
                       input logic [63:0] k_);
      dbg <= d_;
      kn <= n_;
      kk <= k_;
      go <= 1;
      @(posedge CLOCK);
      go <= 0;
      @(posedge CLOCK);
      while (mbusy === 1'b1) @(posedge CLOCK);
      // Let the last command pulse be counted first
      @(posedge CLOCK);
      if (!d_ && m_cfg[5])
         for (int i = 0; i < n_; i++) m_q.push_back(k_[8*i +: 8]);
   endtask : send
   // Clearing key access runs the compare
   task automatic close_key;
      apb(1, fos_pkg::OFS_CONFIG, 32'h0);
      ok = m_cfg[5] && nvb[7] && m_q.size() == 8;
      foreach (m_q[i]) if (m_q[i] != STORED_BACKDOOR_KEY[8*i +: 8]) ok = 0;
      if (ok) m_code = 2;
      m_q.delete();
      m_cfg = 0;
      repeat (3) @(posedge CLOCK);
   endtask : close_key
   task automatic req(input logic e);
      MEM_REQ_VALID <= 1;
      MEM_REQ_UNSECURED_SRC <= 1;
      @(posedge CLOCK);
      MEM_REQ_VALID <= 0;
      @(posedge CLOCK);
      chk_bit(MEM_REQ_DENY, e);
   endtask : req
   // Main sequence
   initial begin
      STORED_BACKDOOR_KEY <= {$random(seed), $random(seed)};
      rst({1'b1, 1'($random(seed)), 4'($random(seed)), 2'h1});
      chk_bit(VECTOR_REDIRECT_EN, !nvb[6]);
      chk_bit(OPTIONS_LOADED, 1'b1);
      chk_bit(SECURE, 1'b1);
      chk_rd(fos_pkg::OFS_OPTIONS, nvb & 8'hc3, 0);
      apb(1, fos_pkg::OFS_OPTIONS, 32'hff);
      chk_rd(fos_pkg::OFS_OPTIONS, nvb & 8'hc3, 0);
      chk_rd(fos_pkg::OFS_CONFIG, 0, 0);
      chk_rd(8'h0c, 0, 1);
      req(1'b1);
      $display("test options done");
      for (int t = 0; t < 4; t++) begin
         d = $random(seed);
         apb(1, fos_pkg::OFS_CONFIG, d);
         m_cfg = d & 32'he0;
         chk_rd(fos_pkg::OFS_CONFIG, m_cfg, 0);
         chk_bit(FLASH_READ_INVALID, m_cfg[5]);
      end
      close_key;
      cmds = 0;
      send(0, 8, STORED_BACKDOOR_KEY);
      chk_bit(cmds == 8, 1'b1);
      chk_bit(cdat === STORED_BACKDOOR_KEY, 1'b1);
      $display("test config done");
      for (int t = 0; t < 4; t++) begin
         apb(1, fos_pkg::OFS_CONFIG, 32'h20);
         m_cfg = 32'h20;
         send(t == 0, (t == 1) ? 4'd7 : 4'd8,
              STORED_BACKDOOR_KEY ^ ((t == 2) ? 64'h100 : 64'h0));
         close_key;
         chk_bit(SECURE, m_code != 2);
         chk_rd(fos_pkg::OFS_STATUS, {m_code == 2, !ok, m_code != 2}, 0);
         $display("test key case %0d done", t);
      end
      chk_rd(fos_pkg::OFS_OPTIONS, (nvb & 8'hc0) | 8'h02, 0);
      req(1'b0);
      rst({1'b0, 1'($random(seed)), 4'($random(seed)), 2'h0});
      chk_bit(VECTOR_REDIRECT_EN, !nvb[6]);
      apb(1, fos_pkg::OFS_CONFIG, 32'h20);
      m_cfg = 32'h20;
      send(0, 8, STORED_BACKDOOR_KEY);
      close_key;
      chk_bit(SECURE, m_code != 2);
      BLANK_CHECK_PASS <= 1;
      @(posedge CLOCK);
      BLANK_CHECK_PASS <= 0;
      repeat (2) @(posedge CLOCK);
      chk_bit(SECURE, 1'b0);
      $display("test disabled key and blank check done");
      test_done;
   end
endmodule : tb_top
`default_nettype wire
